// [hw/pin_function_config_one_regs.svh]
// Register offsets, field positions and reset values of the pin function block.
// Assumes inclusion by bare name from the block's design files.
`ifndef PIN_FUNCTION_CONFIG_ONE_REGS_SVH
`define PIN_FUNCTION_CONFIG_ONE_REGS_SVH

`define ADDR_W        12
`define CFG1_IDX      10'h00e
`define CFG1_ADDR     {`CFG1_IDX, 2'b00}
`define EXT_ADDR      12'h040
`define STS_ADDR      12'h044
`define MASK_ADDR     12'h048
`define PIN_IN_ADDR   12'h04c
`define CFG1_RST      8'h00
`define EXT_RST       18'h00000
`define STS_RST       2'h0
`define FAULT_EN_BIT  7
`define SER_EN_BIT    6
`define PIN2_LSB      3
`define PIN1_LSB      0
`define FIELD_W       3
`define EXT_W         18
`define STS_W         2
`define EV_FAULT_SET  0
`define EV_FAULT_CLR  1
`define SER_SEL_PIN   3
`define SER_CLK_PIN   4
`define SER_DO_PIN    5
`define SER_DI_PIN    6
`define FAULT_PIN     7

`endif

// [hw/pin_cfg_pkg.sv]
// Types shared by the pin function block.
// Assumes nothing of its surroundings.
package pin_cfg_pkg;

    typedef enum logic [2:0] {
        FUNC_OFF       = 3'h0,
        FUNC_ADC_TEMP  = 3'h1,
        FUNC_ADC       = 3'h2,
        FUNC_DIN       = 3'h3,
        FUNC_OUT_HIGH  = 3'h4,
        FUNC_OUT_LOW   = 3'h5,
        FUNC_ADC_PU    = 3'h6,
        FUNC_ADC_PD    = 3'h7
    } pin_func_e;

    typedef struct packed {
        logic drive_en;
        logic drive_val;
        logic pull_up;
        logic pull_down;
        logic adc_en;
        logic temp_cmp_en;
        logic din_en;
    } pin_ctrl_s;

endpackage

// [hw/pin_function_decode.sv]
// Decodes one 3-bit pin function field into pin controls.
// Assumes the caller applies any override.
`timescale 1ns/100ps
`default_nettype none
module pin_function_decode
    import pin_cfg_pkg::*;
(
    // Field in, controls out
    input  wire logic [2:0] field,
    output pin_ctrl_s       ctrl
);

    function automatic pin_ctrl_s decode_func(input logic [2:0] f);
        pin_ctrl_s c;
        c = '0;
        case (pin_func_e'(f))
            FUNC_OFF:      c = '0;
            FUNC_ADC_TEMP:
            begin
                c.adc_en      = 1'b1;
                c.temp_cmp_en = 1'b1;
            end
            FUNC_ADC:      c.adc_en = 1'b1;
            FUNC_DIN:      c.din_en = 1'b1;
            FUNC_OUT_HIGH:
            begin
                c.drive_en  = 1'b1;
                c.drive_val = 1'b1;
            end
            FUNC_OUT_LOW:  c.drive_en = 1'b1;
            FUNC_ADC_PU:
            begin
                c.adc_en  = 1'b1;
                c.pull_up = 1'b1;
            end
            FUNC_ADC_PD:
            begin
                c.adc_en    = 1'b1;
                c.pull_down = 1'b1;
            end
            default:       c = '0;
        endcase
        return c;
    endfunction

    always_comb
    begin
        ctrl = decode_func(field);
    end

endmodule
`default_nettype wire

// [hw/pin_function_config_one.sv]
// Pin function configuration block: APB registers, pin control, fault routing.
// Assumes an APB master on sys_clk and pin pads outside that resolve enables.
`timescale 1ns/100ps
`default_nettype none
`include "pin_function_config_one_regs.svh"
module pin_function_config_one
    import pin_cfg_pkg::*;
#(
    parameter int NPINS = 8
)
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // APB slave
    input  wire logic [`ADDR_W-1:0]   paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Pins 1..8, index 0 is pin 1
    input  wire logic [NPINS-1:0]     pin_in,
    output logic      [NPINS-1:0]     pin_out,
    output logic      [NPINS-1:0]     pin_oe_n,
    output logic      [NPINS-1:0]     pin_pull_up,
    output logic      [NPINS-1:0]     pin_pull_down,
    output logic      [NPINS-1:0]     pin_adc_en,
    output logic      [NPINS-1:0]     pin_temp_cmp_en,
    output logic      [NPINS-1:0]     pin_din_en,
    // Serial controller side
    input  wire logic                 ser_select,
    input  wire logic                 ser_clk,
    input  wire logic                 ser_dout,
    output logic                      ser_din,
    output logic                      ser_enable,
    // Fault and interrupt
    output logic                      fault_alarm_output_n,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]              cfg_reg;
    logic [`EXT_W-1:0]       ext_reg;
    logic [`STS_W-1:0]       sts_reg;
    logic [`STS_W-1:0]       sts_next;
    logic [`STS_W-1:0]       mask_reg;
    logic [NPINS-1:0]        s1_reg;
    logic [NPINS-1:0]        s2_reg;
    logic [NPINS-1:0]        s3_reg;
    logic [NPINS-1:0]        filt_reg;
    logic                    alarm_reg;
    logic [31:0]             rd_data;
    logic                    rd_hit;
    logic                    wr_done;
    logic                    alarm_next;
    logic [NPINS*3-1:0]      fields;
    pin_ctrl_s               dec   [NPINS];
    pin_ctrl_s               final_ctrl [NPINS];

    assign wr_done = psel && penable && pready && pwrite;
    assign fields  = {ext_reg, cfg_reg[`PIN2_LSB +: `FIELD_W], cfg_reg[`PIN1_LSB +: `FIELD_W]};

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: answer in the first access cycle
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            if (psel && !penable)
            begin
                prdata <= pwrite ? 32'h0 : rd_data;
            end
        end
    end

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = 32'h0;
        case (paddr)
            `CFG1_ADDR:   rd_data = {24'h0, cfg_reg};
            `EXT_ADDR:    rd_data = {{(32-`EXT_W){1'b0}}, ext_reg};
            `STS_ADDR:    rd_data = {{(32-`STS_W){1'b0}}, sts_reg};
            `MASK_ADDR:   rd_data = {{(32-`STS_W){1'b0}}, mask_reg};
            `PIN_IN_ADDR: rd_data = {{(32-NPINS){1'b0}}, filt_reg};
            default:      rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cfg_reg  <= `CFG1_RST;
            ext_reg  <= `EXT_RST;
            mask_reg <= `STS_RST;
        end
        else if (wr_done)
        begin
            case (paddr)
                `CFG1_ADDR: cfg_reg  <= pwdata[7:0];
                `EXT_ADDR:  ext_reg  <= pwdata[`EXT_W-1:0];
                `MASK_ADDR: mask_reg <= pwdata[`STS_W-1:0];
                default:    cfg_reg  <= cfg_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers; value accepted once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            s1_reg   <= '1;
            s2_reg   <= '1;
            s3_reg   <= '1;
            filt_reg <= '1;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NPINS; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                begin
                    filt_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field decode and overrides
    for (genvar g = 0; g < NPINS; g++)
    begin : g_dec
        pin_function_decode u_dec (
            .field (fields[g*3 +: 3]),
            .ctrl  (dec[g])
        );
    end

    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            final_ctrl[i] = dec[i];
        end
        if (cfg_reg[`SER_EN_BIT])
        begin
            final_ctrl[`SER_SEL_PIN]           = '0;
            final_ctrl[`SER_SEL_PIN].drive_en  = 1'b1;
            final_ctrl[`SER_SEL_PIN].drive_val = ser_select;
            final_ctrl[`SER_CLK_PIN]           = '0;
            final_ctrl[`SER_CLK_PIN].drive_en  = 1'b1;
            final_ctrl[`SER_CLK_PIN].drive_val = ser_clk;
            final_ctrl[`SER_DO_PIN]            = '0;
            final_ctrl[`SER_DO_PIN].drive_en   = 1'b1;
            final_ctrl[`SER_DO_PIN].drive_val  = ser_dout;
            final_ctrl[`SER_DI_PIN]            = '0;
            final_ctrl[`SER_DI_PIN].din_en     = 1'b1;
        end
        if (cfg_reg[`FAULT_EN_BIT])
        begin
            final_ctrl[`FAULT_PIN]        = '0;
            final_ctrl[`FAULT_PIN].din_en = 1'b1;
        end
    end

    // Pin controls registered: visible the cycle after the field changes
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_out         <= '0;
            pin_oe_n        <= '1;
            pin_pull_up     <= '0;
            pin_pull_down   <= '0;
            pin_adc_en      <= '0;
            pin_temp_cmp_en <= '0;
            pin_din_en      <= '0;
        end
        else
        begin
            for (int i = 0; i < NPINS; i++)
            begin
                pin_out[i]         <= final_ctrl[i].drive_val;
                pin_oe_n[i]        <= !final_ctrl[i].drive_en;
                pin_pull_up[i]     <= final_ctrl[i].pull_up;
                pin_pull_down[i]   <= final_ctrl[i].pull_down;
                pin_adc_en[i]      <= final_ctrl[i].adc_en;
                pin_temp_cmp_en[i] <= final_ctrl[i].temp_cmp_en;
                pin_din_en[i]      <= final_ctrl[i].din_en;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial controller enable and receive data
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ser_enable <= 1'b0;
            ser_din    <= 1'b0;
        end
        else
        begin
            ser_enable <= cfg_reg[`SER_EN_BIT];
            ser_din    <= cfg_reg[`SER_EN_BIT] && filt_reg[`SER_DI_PIN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault routing, events and interrupt
    assign alarm_next = cfg_reg[`FAULT_EN_BIT] && !filt_reg[`FAULT_PIN];
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            alarm_reg            <= 1'b0;
            fault_alarm_output_n <= 1'b1;
        end
        else
        begin
            alarm_reg            <= alarm_next;
            fault_alarm_output_n <= !alarm_next;
        end
    end

    always_comb
    begin
        sts_next = sts_reg;
        if (wr_done && paddr == `STS_ADDR)
        begin
            sts_next = sts_reg & ~pwdata[`STS_W-1:0];
        end
        // Set wins over a clear in the same cycle
        sts_next[`EV_FAULT_SET] = sts_next[`EV_FAULT_SET] || (alarm_next && !alarm_reg);
        sts_next[`EV_FAULT_CLR] = sts_next[`EV_FAULT_CLR] || (!alarm_next && alarm_reg);
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sts_reg <= `STS_RST;
            irq     <= 1'b0;
        end
        else
        begin
            sts_reg <= sts_next;
            irq     <= |(sts_next & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_fault_route;
        cfg_reg[`FAULT_EN_BIT] && !filt_reg[`FAULT_PIN] |=> !fault_alarm_output_n;
    endproperty
    a_fault_route: assert property (p_fault_route) else $error("fault not routed");

    property p_fault_pin_override;
        cfg_reg[`FAULT_EN_BIT] |=> pin_oe_n[`FAULT_PIN] && pin_din_en[`FAULT_PIN]
            && !pin_adc_en[`FAULT_PIN] && !pin_pull_up[`FAULT_PIN];
    endproperty
    a_fault_pin_override: assert property (p_fault_pin_override)
        else $error("pin 8 field used");

    property p_ser_enable;
        ##1 ser_enable == $past(cfg_reg[`SER_EN_BIT]);
    endproperty
    a_ser_enable: assert property (p_ser_enable) else $error("serial enable wrong");

    property p_ser_pins;
        cfg_reg[`SER_EN_BIT] |=> !pin_oe_n[`SER_CLK_PIN] && !pin_oe_n[`SER_DO_PIN]
            && pin_oe_n[`SER_DI_PIN] && pin_din_en[`SER_DI_PIN];
    endproperty
    a_ser_pins: assert property (p_ser_pins) else $error("serial pins not taken");

    property p_decode_low;
        cfg_reg[`PIN1_LSB +: `FIELD_W] == FUNC_ADC_TEMP |=> pin_oe_n[0] && pin_adc_en[0]
            && pin_temp_cmp_en[0] && !pin_din_en[0];
    endproperty
    a_decode_low: assert property (p_decode_low) else $error("code 001 wrong");

    property p_decode_high;
        cfg_reg[`PIN2_LSB +: `FIELD_W] == FUNC_OUT_HIGH |=> !pin_oe_n[1] && pin_out[1];
    endproperty
    a_decode_high: assert property (p_decode_high) else $error("code 100 wrong");

    property p_cfg_reset;
        $past(sys_rst) |-> cfg_reg == `CFG1_RST && pin_oe_n == '1;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not reset");

    property p_select_pin;
        cfg_reg[`SER_EN_BIT] |=> !pin_oe_n[`SER_SEL_PIN]
            && pin_out[`SER_SEL_PIN] == $past(ser_select);
    endproperty
    a_select_pin: assert property (p_select_pin) else $error("select pin wrong");

    property p_write_effect;
        wr_done && paddr == `CFG1_ADDR && pwdata[`PIN1_LSB +: `FIELD_W] == FUNC_OUT_LOW
            |=> ##1 !pin_oe_n[0] && !pin_out[0];
    endproperty
    a_write_effect: assert property (p_write_effect) else $error("write not applied");

endmodule
`default_nettype wire

// [tb/tb_pin_function_config_one.sv]
// Self-checking bench for the pin function configuration block.
// Assumes the design package, the register header and an APB-only host.
`timescale 1ns/100ps
`default_nettype none
`include "pin_function_config_one_regs.svh"
module tb_pin_function_config_one
    import pin_cfg_pkg::*;
;
    logic        sys_clk;
    logic        sys_rst;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pin_in;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe_n;
    logic [7:0]  pin_pull_up;
    logic [7:0]  pin_pull_down;
    logic [7:0]  pin_adc_en;
    logic [7:0]  pin_temp_cmp_en;
    logic [7:0]  pin_din_en;
    logic        ser_select;
    logic        ser_clk;
    logic        ser_dout;
    logic        ser_din;
    logic        ser_enable;
    logic        fault_alarm_output_n;
    logic        irq;
    int          bad_count;
    int          n_checks;
    int          cycles;
    logic [31:0] rdat;
    logic        rerr;

    pin_function_config_one #(.NPINS(8)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
        .pin_adc_en(pin_adc_en), .pin_temp_cmp_en(pin_temp_cmp_en),
        .pin_din_en(pin_din_en), .ser_select(ser_select), .ser_clk(ser_clk),
        .ser_dout(ser_dout), .ser_din(ser_din), .ser_enable(ser_enable),
        .fault_alarm_output_n(fault_alarm_output_n), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 20)
            chk(32'h0, 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, then settle one edge past completion
    task automatic wr_settle(input logic [11:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Expected controls of one pin as {drive, high, pu, pd, adc, temp, din}
    function automatic logic [6:0] exp_ctrl(input logic [2:0] c);
        exp_ctrl = {c == 3'h4 || c == 3'h5, c == 3'h4, c == 3'h6, c == 3'h7,
                    c == 3'h1 || c == 3'h2 || c == 3'h6 || c == 3'h7, c == 3'h1, c == 3'h3};
    endfunction

    function automatic logic [6:0] got_ctrl(input int i);
        got_ctrl = {~pin_oe_n[i], ~pin_oe_n[i] & pin_out[i], pin_pull_up[i],
                    pin_pull_down[i], pin_adc_en[i], pin_temp_cmp_en[i], pin_din_en[i]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        @(negedge sys_clk);
        chk({24'h0, pin_oe_n}, 32'hff);
        chk({31'h0, fault_alarm_output_n}, 32'h1);
        apb(1'b0, `CFG1_ADDR, 32'h0);
        chk(rdat, 32'h0);
    endtask

    task automatic test_decode();
        for (int c = 0; c < 8; c++)
        begin
            wr_settle(`CFG1_ADDR, {26'h0, 3'(7 - c), 3'(c)});
            chk({25'h0, got_ctrl(0)}, {25'h0, exp_ctrl(3'(c))});
            chk({25'h0, got_ctrl(1)}, {25'h0, exp_ctrl(3'(7 - c))});
            apb(1'b0, `CFG1_ADDR, 32'h0);
            chk(rdat, {26'h0, 3'(7 - c), 3'(c)});
        end
    endtask

    task automatic test_unmapped();
        apb(1'b1, 12'h100, 32'hffff_ffff);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
    endtask

    task automatic test_serial();
        // Pins 3..7 as output high, pins 4..7 must be overridden
        wr_settle(`EXT_ADDR, 32'h0000_4924);
        chk({31'h0, pin_oe_n[3]}, 32'h0);
        apb(1'b0, `EXT_ADDR, 32'h0);
        chk(rdat, 32'h0000_4924);
        @(posedge sys_clk);
        ser_select <= 1'b0;
        ser_clk    <= 1'b1;
        wr_settle(`CFG1_ADDR, 32'h40);
        chk({31'h0, ser_enable}, 32'h1);
        chk({29'h0, pin_out[5:3]}, 32'h2);
        chk({28'h0, pin_oe_n[6:3]}, 32'h8);
        chk({31'h0, ser_din}, 32'h1);
        @(posedge sys_clk);
        ser_select <= 1'b1;
        ser_clk    <= 1'b0;
        ser_dout   <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({29'h0, pin_out[5:3]}, 32'h5);
        chk({31'h0, pin_oe_n[3]}, 32'h0);
        wr_settle(`CFG1_ADDR, 32'h0);
        chk({31'h0, ser_enable}, 32'h0);
        chk({29'h0, pin_out[5:3]}, 32'h7);
        chk({31'h0, ser_din}, 32'h0);
    endtask

    task automatic wait_fault(input logic lvl);
        int n;
        n = 0;
        while (fault_alarm_output_n !== lvl && n < 12)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({31'h0, fault_alarm_output_n}, {31'h0, lvl});
    endtask

    task automatic test_fault();
        // Pin 8 output high while fault input off
        wr_settle(`EXT_ADDR, 32'h0002_0000);
        chk({25'h0, got_ctrl(7)}, {25'h0, exp_ctrl(3'h4)});
        wr_settle(`CFG1_ADDR, 32'h80);
        chk({25'h0, got_ctrl(7)}, 32'h1);
        @(posedge sys_clk);
        pin_in <= 8'h7f;
        wait_fault(1'b0);
        apb(1'b0, `PIN_IN_ADDR, 32'h0);
        chk(rdat, 32'h7f);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `STS_ADDR, 32'h0);
        chk(rdat, 32'h1);
        wr_settle(`MASK_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr_settle(`STS_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        @(posedge sys_clk);
        pin_in <= 8'hff;
        wait_fault(1'b1);
        apb(1'b0, `STS_ADDR, 32'h0);
        chk(rdat, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr_settle(`CFG1_ADDR, 32'h0);
        chk({25'h0, got_ctrl(7)}, {25'h0, exp_ctrl(3'h4)});
    endtask

    // Reset in mid-run after every config bit was set
    task automatic test_mid_reset();
        wr_settle(`CFG1_ADDR, 32'hff);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        chk({24'h0, pin_oe_n}, 32'hff);
        chk({31'h0, ser_enable}, 32'h0);
        apb(1'b0, `CFG1_ADDR, 32'h0);
        chk(rdat, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst    = 1'b1;
        paddr      = 12'h000;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        pwdata     = 32'h0;
        pin_in     = 8'hff;
        ser_select = 1'b0;
        ser_clk    = 1'b0;
        ser_dout   = 1'b0;
        bad_count  = 0;
        n_checks   = 0;
        cycles     = 0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_reset();
        test_decode();
        test_unmapped();
        test_serial();
        test_fault();
        test_mid_reset();
        stop_test();
    end
endmodule
`default_nettype wire
